// ===== hdl/evr_map.vh
`ifndef EVR_MAP_VH
`define EVR_MAP_VH
// register byte addresses
`define EVR_SWEV_A_ADDR   8'h00
`define EVR_SWEV_B_ADDR   8'h04
`define EVR_CHAN_BASE     8'h40
`define EVR_CHAN_LAST     8'h64
`define EVR_GEN_ASYNC     8'h08
`define EVR_USER_BASE     8'h80
`define EVR_USER_LAST     8'hBC
// reset values and responses
`define EVR_SEL_RESET     8'h00
`define EVR_SEL_OFF       8'h00
`define EVR_RESP_OKAY     2'b00
`define EVR_RESP_SLVERR   2'b10
// synchroniser depth
`define EVR_SYNC_STAGES   2
`endif

// ===== hdl/evr_router.v
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "evr_map.vh"
module evr_router #(
  parameter NCH   = 10,
  parameter NGEN  = 16,
  parameter NUSER = 16
) (
  // clock and reset
  input  wire                SYS_CLK,
  input  wire                RST,
  // axi4-lite write address
  input  wire [7:0]          S_AXI_AWADDR,
  input  wire                S_AXI_AWVALID,
  output reg                 S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0]         S_AXI_WDATA,
  input  wire [3:0]          S_AXI_WSTRB,
  input  wire                S_AXI_WVALID,
  output reg                 S_AXI_WREADY,
  // axi4-lite write response
  output reg  [1:0]          S_AXI_BRESP,
  output reg                 S_AXI_BVALID,
  input  wire                S_AXI_BREADY,
  // axi4-lite read address
  input  wire [7:0]          S_AXI_ARADDR,
  input  wire                S_AXI_ARVALID,
  output reg                 S_AXI_ARREADY,
  // axi4-lite read data
  output reg  [31:0]         S_AXI_RDATA,
  output reg  [1:0]          S_AXI_RRESP,
  output reg                 S_AXI_RVALID,
  input  wire                S_AXI_RREADY,
  // generator outputs; index 0 unused (off), bit set in GEN_IS_ASYNC marks async kind
  input  wire [NGEN-1:0]     GEN_EVENT,
  input  wire [NGEN-1:0]     GEN_IS_ASYNC,
  // channel subchannels
  output reg  [NCH-1:0]      CH_ASYNC,
  output reg  [NCH-1:0]      CH_SYNC,
  // per-user event inputs: async/raw and synchronous taps
  output reg  [NUSER-1:0]    USER_ASYNC,
  output reg  [NUSER-1:0]    USER_SYNC
);
  localparam CHW = 4;
  localparam UW  = 4;
  localparam GW  = 4;

  // write path state
  reg              aw_got_q;
  reg              w_got_q;
  reg  [7:0]       aw_addr_q;
  reg  [31:0]      w_data_q;
  reg  [3:0]       w_strb_q;
  // software strobes, one cycle each
  reg  [NCH-1:0]   swev_q;
  // user channel selectors
  reg  [CHW-1:0]   user_sel_q [0:NUSER-1];
  // read state
  reg              rd_pend_q;
  reg  [7:0]       ar_addr_q;

  wire             wr_go;
  wire             chan_hit_w;
  wire [3:0]       chan_idx_w;
  wire [NCH*8-1:0] chan_flat;
  wire [7:0]       chan_rd;
  wire [NCH-1:0]   ch_raw;
  wire [NCH-1:0]   ch_isasync;
  wire [NCH-1:0]   ch_synced;
  reg  [NCH-1:0]   ch_async_d;
  reg  [NCH-1:0]   ch_sync_d;
  reg  [NUSER-1:0] user_async_d;
  reg  [NUSER-1:0] user_sync_d;
  reg  [NCH-1:0]   swev_d;
  reg  [31:0]      rdata_d;
  reg  [1:0]       rresp_d;

  wire [3:0]       chan_rd_idx;
  wire [3:0]       user_wr_idx;
  wire [3:0]       user_rd_idx;
  wire             swev_a_hit;
  wire             swev_b_hit;
  wire             user_wr_hit;
  wire             map_hit_w;

  integer          k;
  integer          ku;
  integer          kr;
  genvar           g;

  function chan_hit;
    input [7:0] a;
    begin
      chan_hit = (a >= `EVR_CHAN_BASE) && (a <= `EVR_CHAN_LAST) && (a[1:0] == 2'b00);
    end
  endfunction

  function user_hit;
    input [7:0] a;
    begin
      user_hit = (a >= `EVR_USER_BASE) && (a <= `EVR_USER_LAST) && (a[1:0] == 2'b00);
    end
  endfunction

  function [3:0] word_idx;
    input [7:0] a;
    input [7:0] base;
    reg   [7:0] diff;
    begin
      diff     = a - base;
      word_idx = diff[5:2];
    end
  endfunction

  assign wr_go      = aw_got_q && w_got_q && !S_AXI_BVALID;
  assign chan_hit_w = chan_hit(aw_addr_q) && w_strb_q[0];
  assign chan_idx_w = word_idx(aw_addr_q, `EVR_CHAN_BASE);

  // write address decode for the strobe, user and error paths
  assign swev_a_hit  = (aw_addr_q == `EVR_SWEV_A_ADDR);
  assign swev_b_hit  = (aw_addr_q == `EVR_SWEV_B_ADDR);
  assign user_wr_hit = user_hit(aw_addr_q);
  assign map_hit_w   = swev_a_hit || swev_b_hit || user_wr_hit ||
                       chan_hit(aw_addr_q);
  assign user_wr_idx = word_idx(aw_addr_q, `EVR_USER_BASE);
  assign user_rd_idx = word_idx(ar_addr_q, `EVR_USER_BASE);

  // selector read is registered, so address it on the accepting edge already;
  // otherwise the answer would carry the previous read's selector
  assign chan_rd_idx = (S_AXI_ARVALID && S_AXI_ARREADY) ?
                       word_idx(S_AXI_ARADDR, `EVR_CHAN_BASE) :
                       word_idx(ar_addr_q, `EVR_CHAN_BASE);

  // generator selectors, one byte per channel
  evr_selmem #(
    .DEPTH (NCH),
    .AW    (4)
  ) u_chan_sel (
    .clk      (SYS_CLK),
    .rst      (RST),
    .wr_en    (wr_go && chan_hit_w),
    .wr_addr  (chan_idx_w),
    .wr_data  (w_data_q[7:0]),
    .rd_addr  (chan_rd_idx),
    .rd_data  (chan_rd),
    .all_data (chan_flat)
  );

  // combinational routing into ch_raw; the outputs still change only on a SYS_CLK edge
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      wire [7:0] sel = chan_flat[g*8 +: 8];
      wire       on  = (sel != `EVR_SEL_OFF) && (sel < NGEN);
      assign ch_raw[g]     = on ? GEN_EVENT[sel[GW-1:0]] : 1'b0;
      assign ch_isasync[g] = on ? GEN_IS_ASYNC[sel[GW-1:0]] : 1'b0;
      evr_sync #(
        .STAGES (`EVR_SYNC_STAGES)
      ) u_sync (
        .clk  (SYS_CLK),
        .rst  (RST),
        .din  (ch_raw[g]),
        .dout (ch_synced[g])
      );
    end
  endgenerate

  // subchannel forming with software inversion
  always @* begin
    for (k = 0; k < NCH; k = k + 1) begin
      ch_async_d[k] = ch_raw[k] ^ swev_q[k];
      ch_sync_d[k]  = (ch_isasync[k] ? ch_synced[k] : ch_raw[k]) ^ swev_q[k];
    end
  end

  // user taps follow each user's own selector
  // selector value v picks channel v-1; zero or out of range leaves the tap quiet
  always @* begin
    for (ku = 0; ku < NUSER; ku = ku + 1) begin
      user_async_d[ku] = 1'b0;
      user_sync_d[ku]  = 1'b0;
      if (user_sel_q[ku] != 4'h0 && user_sel_q[ku] <= NCH) begin
        user_async_d[ku] = ch_async_d[user_sel_q[ku] - 4'h1];
        user_sync_d[ku]  = ch_sync_d[user_sel_q[ku] - 4'h1];
      end
    end
  end

  // outputs registered as house style requires; no debug halt input exists
  always @(posedge SYS_CLK) begin
    if (RST) begin
      CH_ASYNC   <= {NCH{1'b0}};
      CH_SYNC    <= {NCH{1'b0}};
      USER_ASYNC <= {NUSER{1'b0}};
      USER_SYNC  <= {NUSER{1'b0}};
    end else begin
      CH_ASYNC   <= ch_async_d;
      CH_SYNC    <= ch_sync_d;
      USER_ASYNC <= user_async_d;
      USER_SYNC  <= user_sync_d;
    end
  end

  // software strobe word, byte lane 0 only
  always @* begin
    swev_d = {NCH{1'b0}};
    if (wr_go && w_strb_q[0]) begin
      if (swev_a_hit) begin
        swev_d[7:0] = w_data_q[7:0];
      end else if (swev_b_hit) begin
        swev_d[NCH-1:8] = w_data_q[NCH-9:0];
      end
    end
  end

  // strobe lives exactly one clock, then the channel returns to its base level
  always @(posedge SYS_CLK) begin
    if (RST) begin
      swev_q <= {NCH{1'b0}};
    end else begin
      swev_q <= swev_d;
    end
  end

  // user selectors, written only with byte lane 0
  always @(posedge SYS_CLK) begin
    if (RST) begin
      for (kr = 0; kr < NUSER; kr = kr + 1) begin
        user_sel_q[kr] <= 4'h0;
      end
    end else if (wr_go && user_wr_hit && w_strb_q[0]) begin
      user_sel_q[user_wr_idx] <= w_data_q[3:0];
    end
  end

  // axi write channel
  always @(posedge SYS_CLK) begin
    if (RST) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `EVR_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_got_q && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_got_q && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q  <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (map_hit_w) begin
          S_AXI_BRESP <= `EVR_RESP_OKAY;
        end else begin
          S_AXI_BRESP <= `EVR_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read data and response for the held read address
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `EVR_RESP_OKAY;
    if (chan_hit(ar_addr_q)) begin
      rdata_d = {24'h000000, chan_rd};
    end else if (user_hit(ar_addr_q)) begin
      rdata_d = {28'h0000000, user_sel_q[user_rd_idx]};
    end else if (ar_addr_q == `EVR_GEN_ASYNC) begin
      rdata_d = {{(32-NCH){1'b0}}, ch_isasync};
    end else if (ar_addr_q != `EVR_SWEV_A_ADDR && ar_addr_q != `EVR_SWEV_B_ADDR) begin
      rresp_d = `EVR_RESP_SLVERR;
    end
  end

  // axi read channel; one wait cycle for the registered selector read
  always @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `EVR_RESP_OKAY;
      rd_pend_q     <= 1'b0;
      ar_addr_q     <= 8'h00;
    end else begin
      S_AXI_ARREADY <= !rd_pend_q && !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rd_pend_q <= 1'b1;
        ar_addr_q <= S_AXI_ARADDR;
      end else if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= rresp_d;
        S_AXI_RDATA  <= rdata_d;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// ===== hdl/evr_selmem.v
`timescale 1ns/1ps
// small register memory for selector bytes, registered read port
module evr_selmem #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire                clk,
  input  wire                rst,
  // write port
  input  wire                wr_en,
  input  wire [AW-1:0]       wr_addr,
  input  wire [7:0]          wr_data,
  // read port
  input  wire [AW-1:0]       rd_addr,
  output reg  [7:0]          rd_data,
  // flat view of all entries
  output wire [DEPTH*8-1:0]  all_data
);
  reg [7:0] mem_q [0:DEPTH-1];
  integer i;
  genvar g;

  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
    end
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : flat
      assign all_data[g*8 +: 8] = mem_q[g];
    end
  endgenerate
endmodule

// ===== hdl/evr_sync.v
`timescale 1ns/1ps
// level resynchroniser to the peripheral clock; first stage read only by the second
module evr_sync #(
  parameter STAGES = 2
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // data
  input  wire din,
  output wire dout
);
  reg [STAGES-1:0] chain_q;

  always @(posedge clk) begin
    if (rst) begin
      chain_q <= {STAGES{1'b0}};
    end else begin
      chain_q <= {chain_q[STAGES-2:0], din};
    end
  end

  assign dout = chain_q[STAGES-1];
endmodule

// ===== verif/evr_gen_model.sv
`timescale 1ns/1ps
module evr_gen_model #(
  parameter            NGEN       = 16,
  parameter [NGEN-1:0] ASYNC_MASK = 16'hFF00
) (
  // clock
  input  wire            clk,
  // generator side
  output reg  [NGEN-1:0] gen_event,
  output wire [NGEN-1:0] gen_is_async
);
  assign gen_is_async = ASYNC_MASK;
  initial gen_event = '0;
  // unclocked generators move off the clock edge
  task automatic drive(input int i, input logic v);
    begin
      @(posedge clk);
      if (ASYNC_MASK[i]) begin
        #13;
        gen_event[i] = v;
      end else begin
        gen_event[i] <= v;
      end
    end
  endtask
endmodule

// ===== verif/evr_router_sva.sv
`timescale 1ns/1ps
module evr_router_sva #(
  parameter NCH = 10
) (
  // clock and reset
  input wire           SYS_CLK,
  input wire           RST,
  // bus handshakes
  input wire           S_AXI_AWVALID,
  input wire           S_AXI_AWREADY,
  input wire           S_AXI_WVALID,
  input wire           S_AXI_WREADY,
  input wire           S_AXI_BVALID,
  input wire           S_AXI_BREADY,
  input wire           S_AXI_ARVALID,
  input wire           S_AXI_ARREADY,
  input wire           S_AXI_RVALID,
  input wire           S_AXI_RREADY,
  // channel outputs
  input wire [NCH-1:0] CH_ASYNC,
  input wire [NCH-1:0] CH_SYNC
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_reset_quiet: assert property (disable iff (1'b0)
    RST |=> !S_AXI_BVALID && !S_AXI_RVALID && CH_ASYNC == '0 && CH_SYNC == '0)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_b_cause: assert property (
    $rose(S_AXI_BVALID) |-> $past(S_AXI_WVALID && S_AXI_WREADY || S_AXI_AWVALID && S_AXI_AWREADY, 2))
    else $error("write response without request");
  a_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not released");
  a_aw_once: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("write address ready held");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_RVALID ##1 S_AXI_RVALID)
    else $error("read data timing wrong");
  a_r_cause: assert property (
    $rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID && S_AXI_ARREADY, 2))
    else $error("read data without request");
  a_r_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data not released");
endmodule
bind evr_router evr_router_sva #(.NCH(NCH)) u_sva (.SYS_CLK, .RST, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .CH_ASYNC, .CH_SYNC);

// ===== verif/evr_router_tb.sv
`timescale 1ns/1ps
module evr_router_tb;
  reg         sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] gen, gasync, ua, us;
  wire [9:0]  ca, cs;
  int         mismatches, cmp_count, la, ls;
  evr_gen_model u_gen (.clk(sys_clk), .gen_event(gen), .gen_is_async(gasync));
  evr_router u_dut (
    .SYS_CLK(sys_clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GEN_EVENT(gen), .GEN_IS_ASYNC(gasync), .CH_ASYNC(ca), .CH_SYNC(cs),
    .USER_ASYNC(ua), .USER_SYNC(us));
  task automatic cmp(input [31:0] got, input [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        mismatches++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge sys_clk);
        n++;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      bready <= 1'b0;
      cmp({29'h0, !bvalid, bresp}, {30'h0, er});
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge sys_clk);
        n++;
        if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      rready <= 1'b0;
      cmp(rdata, ed);
      cmp({29'h0, !rvalid, rresp}, {30'h0, er});
    end
  endtask
  // cycles until a rising generator shows on both subchannels
  task automatic lat(input int g, input int c);
    begin
      la = 0;
      ls = 0;
      u_gen.drive(g, 1'b1);
      for (int k = 1; k <= 8; k++) begin
        @(negedge sys_clk);
        if (la == 0 && ca[c] === 1'b1) la = k;
        if (ls == 0 && cs[c] === 1'b1) ls = k;
      end
    end
  endtask
  // software strobe; every tap must differ from its base for one cycle
  task automatic flips(input int c, input int u, input [7:0] a);
    logic [7:0] na, ns, nu, nv;
    logic       b;
    begin
      {na, ns, nu, nv} = '0;
      b = ca[c];
      wr(a, 32'h1 << (c % 8), 2'b00);
      for (int k = 0; k < 8; k++) begin
        @(negedge sys_clk);
        na += (ca[c] !== b);
        ns += (cs[c] !== b);
        nu += (ua[u] !== b);
        nv += (us[u] !== b);
      end
      cmp({na, ns, nu, nv}, 32'h01010101);
    end
  endtask
  task automatic give_verdict;
    begin
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    cmp({ca, cs, ua[11:0]}, 32'h0);
    rd(8'h40, 32'h0, 2'b00);
    wr(8'h40, 32'h01, 2'b00);
    wr(8'h44, 32'h08, 2'b00);
    wr(8'h60, 32'h02, 2'b00);
    wr(8'h80, 32'h01, 2'b00);
    wr(8'h88, 32'h02, 2'b00);
    wr(8'hBC, 32'h09, 2'b00);
    rd(8'h44, 32'h08, 2'b00);
    wstrb <= 4'h0;
    wr(8'h80, 32'h05, 2'b00);
    wstrb <= 4'hF;
    rd(8'h80, 32'h01, 2'b00);
    rd(8'h08, 32'h02, 2'b00);
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h20, 32'h0, 2'b10);
    wr(8'h20, 32'hFF, 2'b10);
    lat(1, 0);
    cmp(la, 2);
    cmp(ls, 2);
    lat(8, 1);
    cmp(la, 2);
    cmp({31'h0, (ls - la) inside {[2:3]}}, 1);
    cmp({25'h0, ua[0], us[0], ua[2], us[2], ua[15], us[15], ua[1]}, 7'h78);
    flips(0, 0, 8'h00);
    flips(8, 15, 8'h04);
    wr(8'h40, 32'h00, 2'b00);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp({30'h0, ca[0], ua[0]}, 32'h0);
    give_verdict;
  end
endmodule
